/* File: tb/fpc_stage_model.sv */
// power stage and sensor model that paces the pwm cycle
`timescale 1ns/100ps
module fpc_stage_model #(
	parameter int PERIOD = 16
) (
	// clock and reset
	input  wire logic              clk_in,
	input  wire logic              reset_in,
	// supply level chosen by the bench
	input  wire logic [15:0]       supply_set_in,
	// sensor side
	output logic                   tick_out,
	output logic [15:0]            supply_out,
	output logic signed [15:0]     i_u_out,
	output logic signed [15:0]     i_v_out,
	output logic signed [15:0]     i_w_out,
	output logic signed [15:0]     sin_out,
	output logic signed [15:0]     cos_out
);
	logic [7:0] cnt_q;
	initial begin
		sin_out = 16'sh0;
		cos_out = 16'sh7fff;
	end
	// one tick at the start of every pwm period
	always @(posedge clk_in) begin
		if (reset_in) begin
			cnt_q <= 8'h0;
			tick_out <= 1'b0;
		end else begin
			cnt_q <= (cnt_q == 8'(PERIOD - 1)) ? 8'h0 : cnt_q + 8'h1;
			tick_out <= (cnt_q == 8'h0);
		end
	end
	// measurements settle one clock late; phase currents sum to zero
	always @(posedge clk_in) begin
		supply_out <= supply_set_in;
		i_u_out <= {8'h0, cnt_q};
		i_v_out <= -{8'h0, cnt_q};
		i_w_out <= 16'sh0;
	end
endmodule : fpc_stage_model

/* File: tb/tb_fpc_core.sv */
// self-checking testbench of the servo control core
`timescale 1ns/100ps
`include "fpc_cfg.svh"
module tb_fpc_core;
	// ****************************************
	// signals
	// ****************************************
	logic                clk_sys_in = 1'b0;
	logic                reset_in = 1'b1;
	logic                hsel = 1'b0;
	logic [31:0]         haddr = 32'h0;
	logic [1:0]          htrans = 2'h0;
	logic                hwrite = 1'b0;
	logic [2:0]          hsize = 3'h2;
	logic [31:0]         hwdata = 32'h0;
	logic                hready;
	logic                hresp;
	logic [31:0]         hrdata;
	logic                tick;
	logic signed [15:0]  i_u, i_v, i_w, sn, cs;
	logic signed [31:0]  vact = 32'sh0;
	logic signed [31:0]  pact = 32'sh0;
	logic signed [31:0]  sdp = 32'sh0;
	logic signed [15:0]  ana = 16'sh0;
	logic signed [15:0]  pwt = 16'sh0;
	logic                pok = 1'b0;
	logic [15:0]         sup_set = 16'h0;
	logic [15:0]         sup;
	fpc_pkg::fpc_phase_s ph;
	logic                brk;
	int                  errors = 0;
	int                  n_tests = 0;

	always #2 clk_sys_in = ~clk_sys_in;

	fpc_stage_model fpc_stage_model_inst (.clk_in(clk_sys_in),
		.reset_in(reset_in), .supply_set_in(sup_set), .tick_out(tick),
		.supply_out(sup), .i_u_out(i_u), .i_v_out(i_v), .i_w_out(i_w),
		.sin_out(sn), .cos_out(cs));

	fpc_core fpc_core_inst (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
		.hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
		.hready_in(hready), .hreadyout_out(hready), .hresp_out(hresp),
		.hrdata_out(hrdata), .pwm_tick_in(tick), .i_u_in(i_u),
		.i_v_in(i_v), .i_w_in(i_w), .sin_in(sn), .cos_in(cs),
		.vel_act_in(vact), .pos_act_in(pact), .stepdir_pos_in(sdp),
		.analog_target_input_in(ana), .pwm_target_in(pwt),
		.pwm_target_ok_in(pok), .supply_in(sup), .phase_out(ph),
		.brake_out(brk));

	// ****************************************
	// tasks
	// ****************************************
	task report_and_stop;
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : report_and_stop

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// ready seen at the negedge is what the next rising edge samples
	task wait_rdy(output logic [31:0] d);
		int k;
		logic r;
		k = 0;
		do begin
			@(negedge clk_sys_in);
			r = hready;
			d = hrdata;
			@(posedge clk_sys_in);
			k++;
		end while (r !== 1'b1 && k < 16);
		chk({31'h0, r}, 32'h1);
	endtask : wait_rdy

	task bus(input logic w, input logic [7:0] ix, input logic [31:0] wd,
		output logic [31:0] rd);
		logic [31:0] t;
		hsel <= 1'b1;
		haddr <= {22'h0, ix, 2'b00};
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy(t);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy(rd);
	endtask : bus

	task wr(input logic [7:0] ix, input logic [31:0] d);
		logic [31:0] t;
		bus(1'b1, ix, d, t);
	endtask : wr

	task rdc(input logic [7:0] ix, input logic [31:0] e);
		logic [31:0] t;
		bus(1'b0, ix, 32'h0, t);
		chk(t, e);
		chk({31'h0, hresp}, 32'h0);
	endtask : rdc

	// two pwm ticks, then outputs have settled
	task tk;
		repeat (2) begin
			do @(negedge clk_sys_in); while (tick !== 1'b1);
			@(posedge clk_sys_in);
		end
		repeat (2) @(posedge clk_sys_in);
	endtask : tk

	task mcase(input logic [31:0] m, input logic [7:0] s,
		input logic [31:0] e);
		wr(`FPC_IX_MODE, m);
		wr(`FPC_IX_ISEL, {24'h0, s});
		tk();
		rdc(`FPC_IX_INTERIM, e);
	endtask : mcase

	task bstep(input logic [15:0] s, input logic e);
		sup_set <= s;
		tk();
		chk({31'h0, brk}, {31'h0, e});
	endtask : bstep

	// ****************************************
	// sequence
	// ****************************************
	initial begin
		repeat (20000) @(posedge clk_sys_in);
		errors++;
		$display("[FAIL] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
		report_and_stop();
	end

	initial begin
		repeat (3) @(posedge clk_sys_in);
		reset_in <= 1'b0;
		rdc(`FPC_IX_VLIM, 32'h0000_7fff);
		rdc(`FPC_IX_TFLIM, 32'h0000_7fff);
		rdc(`FPC_IX_VELLIM, 32'h7fff_ffff);
		rdc(`FPC_IX_POSMIN, 32'h8000_0000);
		rdc(`FPC_IX_POSMAX, 32'h7fff_ffff);
		wr(8'h7f, 32'hdead_beef);
		rdc(8'h7f, 32'h0);
		wr(`FPC_IX_VELLIM, 32'h64);
		wr(`FPC_IX_POSMIN, 32'hffff_ffce);
		wr(`FPC_IX_POSMAX, 32'hc8);
		wr(`FPC_IX_TFLIM, 32'h1e);
		rdc(`FPC_IX_POSMIN, 32'hffff_ffce);
		wr(`FPC_IX_TGT_VEL, 32'h1f4);
		mcase(32'h22, 8'h2, 32'h64);
		wr(`FPC_IX_TGT_VEL, 32'hffff_fe0c);
		mcase(32'h22, 8'h2, 32'hffff_ff9c);
		wr(`FPC_IX_TGT_POS, 32'h3e8);
		mcase(32'h23, 8'h3, 32'hc8);
		wr(`FPC_IX_TGT_POS, 32'hffff_fc18);
		mcase(32'h23, 8'h3, 32'hffff_ffce);
		// small voltage limit and strong gain drive the torque loop to it
		wr(`FPC_IX_GAIN_TF, 32'h0000_0400);
		wr(`FPC_IX_VLIM, 32'h14);
		wr(`FPC_IX_TGT_TQ, 32'h64);
		mcase(32'h21, 8'h0, 32'h1e);
		wr(`FPC_IX_TGT_TQ, 32'hffff_ff9c);
		mcase(32'h21, 8'h0, 32'hffff_ffe2);
		wr(`FPC_IX_FLUX, 32'hffff_fc18);
		mcase(32'h21, 8'h1, 32'hffff_ffe2);
		// position gain 0.5 in q4.12: error 40 asks for velocity 20
		wr(`FPC_IX_GAIN_POS, 32'h0000_0800);
		wr(`FPC_IX_TGT_POS, 32'h28);
		mcase(32'h23, 8'h2, 32'h14);
		mcase(32'h0c23, 8'h3, 32'h28);
		// velocity gain 1/16 in q8.8: error 100 asks for torque 6
		wr(`FPC_IX_GAIN_VEL, 32'h0000_0010);
		wr(`FPC_IX_TGT_VEL, 32'h64);
		mcase(32'h22, 8'h0, 32'h6);
		sdp <= 32'sd150;
		mcase(32'h223, 8'h3, 32'h96);
		sdp <= 32'sd500;
		mcase(32'h223, 8'h3, 32'hc8);
		// scaler gain 1.0, offset 10
		wr(`FPC_IX_SCALE, 32'h0100_000a);
		ana <= -16'sd40;
		mcase(32'h2b, 8'h2, 32'hffff_ffce);
		ana <= 16'sd40;
		mcase(32'h2c, 8'h3, 32'h1e);
		pwt <= 16'sd310;
		pok <= 1'b1;
		mcase(32'h2e, 8'h2, 32'h64);
		rdc(`FPC_IX_STATUS, 32'h1);
		mcase(32'h2f, 8'h3, 32'hc8);
		pwt <= 16'sd0;
		pok <= 1'b0;
		mcase(32'h2f, 8'h3, 32'hc8);
		mcase(32'h2e, 8'h2, 32'h0);
		mcase(32'h2d, 8'h0, 32'h0);
		for (int m = 4; m < 10; m++) begin
			if (m != 8) begin
				wr(`FPC_IX_MODE, 32'(m));
				tk();
				rdc(`FPC_IX_STATUS, 32'h4);
			end
		end
		wr(`FPC_IX_UDUQ, 32'h03e8_0000);
		wr(`FPC_IX_MODE, 32'h8);
		tk();
		chk({16'h0, ph.u}, 32'h03e8);
		chk({16'h0, ph.v}, 32'hfc18);
		chk({ph.w, ph.y}, 32'h0);
		wr(`FPC_IX_MODE, 32'h0);
		tk();
		chk({ph.u, ph.v}, 32'h0);
		// upper 1000, lower 500
		wr(`FPC_IX_BRAKE, 32'h01f4_03e8);
		bstep(16'd1200, 1'b1);
		repeat (8) @(posedge clk_sys_in);
		chk({31'h0, brk}, 32'h1);
		bstep(16'd800, 1'b1);
		bstep(16'd400, 1'b0);
		bstep(16'd800, 1'b0);
		wr(`FPC_IX_BRAKE, 32'h0);
		bstep(16'd1200, 1'b0);
		report_and_stop();
	end
endmodule : tb_fpc_core

/* File: verilog/fpc_cfg.svh */
// register indices, reset values, field positions and scalings
`ifndef FPC_CFG_SVH
`define FPC_CFG_SVH
`define FPC_IX_MODE     8'h50
`define FPC_IX_GAIN_TF  8'h51
`define FPC_IX_GAIN_VEL 8'h52
`define FPC_IX_GAIN_POS 8'h53
`define FPC_IX_TGT_TQ   8'h54
`define FPC_IX_TGT_VEL  8'h55
`define FPC_IX_TGT_POS  8'h56
`define FPC_IX_SCALE    8'h57
`define FPC_IX_BRAKE    8'h58
`define FPC_IX_STATUS   8'h59
`define FPC_IX_UDUQ     8'h5a
`define FPC_IX_VLIM     8'h5d
`define FPC_IX_TFLIM    8'h5e
`define FPC_IX_VELLIM   8'h60
`define FPC_IX_POSMIN   8'h61
`define FPC_IX_POSMAX   8'h62
`define FPC_IX_FLUX     8'h64
`define FPC_IX_INTERIM  8'h6e
`define FPC_IX_ISEL     8'h6f
`define FPC_S16_MAX     32'sh0000_7fff
`define FPC_S32_MAX     32'sh7fff_ffff
`define FPC_S32_MIN     32'sh8000_0000
`define FPC_F_MM        3:0
`define FPC_F_MOTOR     5:4
`define FPC_B_ADV       6
`define FPC_B_PQ412     7
`define FPC_B_IQ412     8
`define FPC_B_STEPDIR   9
`define FPC_F_DS        16:10
`define FPC_F_LO16      15:0
`define FPC_F_HI16      31:16
`define FPC_MM_STOP     4'h0
`define FPC_MM_TQ       4'h1
`define FPC_MM_VEL      4'h2
`define FPC_MM_POS      4'h3
`define FPC_MM_UDUQ     4'h8
`define FPC_MM_A_TQ     4'ha
`define FPC_MM_A_VEL    4'hb
`define FPC_MM_A_POS    4'hc
`define FPC_MM_P_TQ     4'hd
`define FPC_MM_P_VEL    4'he
`define FPC_MM_P_POS    4'hf
`define FPC_MOT_DC      2'h0
`define FPC_MOT_TWO     2'h1
`define FPC_Q88         8
`define FPC_Q412        12
`define FPC_Q015        15
`define FPC_ADV_DIV     8
`define FPC_SCALE_SH    8
`define FPC_TRIG_SH     15
`define FPC_INV_SQRT3   64'sd18919
`define FPC_SQRT3_HALF  64'sd28378
`endif

/* File: verilog/fpc_core.sv */
// servo control core: target clipping, pi cascade, transforms, brake
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "fpc_cfg.svh"
module fpc_core (
	// clock and reset
	input  wire logic                clk_sys_in,
	input  wire logic                reset_in,
	// ahb-lite slave
	input  wire logic                hsel_in,
	input  wire logic [31:0]         haddr_in,
	input  wire logic [1:0]          htrans_in,
	input  wire logic                hwrite_in,
	input  wire logic [2:0]          hsize_in,
	input  wire logic [31:0]         hwdata_in,
	input  wire logic                hready_in,
	output logic                     hreadyout_out,
	output logic                     hresp_out,
	output logic [31:0]              hrdata_out,
	// measurements and target sources
	input  wire logic                pwm_tick_in,
	input  wire logic signed [15:0]  i_u_in,
	input  wire logic signed [15:0]  i_v_in,
	input  wire logic signed [15:0]  i_w_in,
	input  wire logic signed [15:0]  sin_in,
	input  wire logic signed [15:0]  cos_in,
	input  wire logic signed [31:0]  vel_act_in,
	input  wire logic signed [31:0]  pos_act_in,
	input  wire logic signed [31:0]  stepdir_pos_in,
	input  wire logic signed [15:0]  analog_target_input_in,
	input  wire logic signed [15:0]  pwm_target_in,
	input  wire logic                pwm_target_ok_in,
	input  wire logic [15:0]         supply_in,
	// power stage
	output fpc_pkg::fpc_phase_s      phase_out,
	output logic                     brake_out
);
	typedef logic signed [31:0] fpc_w_t;
	typedef logic signed [63:0] fpc_l_t;

	// ****************************************
	// arithmetic helpers
	// ****************************************
	function automatic fpc_w_t sat(input fpc_l_t v, input fpc_w_t lo,
		input fpc_w_t hi);
		if (v > fpc_l_t'(hi)) return hi;
		else if (v < fpc_l_t'(lo)) return lo;
		else return fpc_w_t'(v);
	endfunction : sat

	function automatic fpc_pkg::fpc_pi_s pi_step(input fpc_w_t e,
		input logic signed [15:0] p, input logic signed [15:0] i,
		input fpc_w_t integ, input fpc_w_t lim, input logic adv,
		input logic pq, input logic iq, input logic pos);
		fpc_pkg::fpc_pi_s r;
		fpc_l_t pe;
		fpc_l_t il;
		int ps;
		int is;
		pe = fpc_l_t'(p) * fpc_l_t'(e);
		ps = pq ? `FPC_Q412 : `FPC_Q88;
		is = iq ? `FPC_Q412 : `FPC_Q88;
		if (adv) begin
			r.integ = sat(fpc_l_t'(integ) + ((pe * fpc_l_t'(i)) >>>
				(ps + is + `FPC_ADV_DIV)), -lim, lim);
			r.out = sat((pe >>> ps) + fpc_l_t'(r.integ), -lim, lim);
		end else begin
			ps = pos ? `FPC_Q412 : `FPC_Q88;
			il = (i == 16'sh0000) ? fpc_l_t'(`FPC_S32_MAX)
				: fpc_l_t'(lim) / fpc_l_t'(i);
			r.integ = pos ? '0 : sat(fpc_l_t'(integ) + fpc_l_t'(e),
				-sat(il, 32'sh0, `FPC_S32_MAX),
				sat(il, 32'sh0, `FPC_S32_MAX));
			r.out = sat((pe >>> ps) + ((fpc_l_t'(i) *
				fpc_l_t'(r.integ)) >>> `FPC_Q015), -lim, lim);
		end
		return r;
	endfunction : pi_step

	// ****************************************
	// registers and bus slave
	// ****************************************
	logic [31:0] mode_q, gtf_q, gvel_q, gpos_q, ttq_q, tvel_q, tpos_q;
	logic [31:0] scale_q, brk_q, uduq_q, vlim_q, tflim_q, vellim_q;
	logic [31:0] posmin_q, posmax_q, flux_q;
	logic [1:0]  isel_q;
	logic [7:0]  ix_q;
	logic        wr_act_q, rd_pend_q;
	logic [31:0] rd_d, hrdata_q;
	fpc_w_t      ctq_q, cfx_q, cvel_q, cpos_q;
	logic        brake_q, reserved_mode;

	assign hreadyout_out = !rd_pend_q;
	assign hresp_out = 1'b0;
	assign hrdata_out = hrdata_q;

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			ix_q <= 8'h00;
			wr_act_q <= 1'b0;
			rd_pend_q <= 1'b0;
		end else begin
			if (rd_pend_q) begin
				rd_pend_q <= 1'b0;
				wr_act_q <= 1'b0;
			end else if (hsel_in && htrans_in[1] && hready_in) begin
				ix_q <= haddr_in[9:2];
				wr_act_q <= hwrite_in;
				rd_pend_q <= !hwrite_in;
			end else begin
				wr_act_q <= 1'b0;
			end
		end
	end

	always_comb begin
		case (ix_q)
			`FPC_IX_MODE: rd_d = mode_q;
			`FPC_IX_GAIN_TF: rd_d = gtf_q;
			`FPC_IX_GAIN_VEL: rd_d = gvel_q;
			`FPC_IX_GAIN_POS: rd_d = gpos_q;
			`FPC_IX_TGT_TQ: rd_d = ttq_q;
			`FPC_IX_TGT_VEL: rd_d = tvel_q;
			`FPC_IX_TGT_POS: rd_d = tpos_q;
			`FPC_IX_SCALE: rd_d = scale_q;
			`FPC_IX_BRAKE: rd_d = brk_q;
			`FPC_IX_STATUS: rd_d = {29'h0, reserved_mode, brake_q,
				pwm_target_ok_in};
			`FPC_IX_UDUQ: rd_d = uduq_q;
			`FPC_IX_VLIM: rd_d = vlim_q;
			`FPC_IX_TFLIM: rd_d = tflim_q;
			`FPC_IX_VELLIM: rd_d = vellim_q;
			`FPC_IX_POSMIN: rd_d = posmin_q;
			`FPC_IX_POSMAX: rd_d = posmax_q;
			`FPC_IX_FLUX: rd_d = flux_q;
			`FPC_IX_ISEL: rd_d = {30'h0, isel_q};
			`FPC_IX_INTERIM: begin
				case (isel_q)
					2'h0: rd_d = ctq_q;
					2'h1: rd_d = cfx_q;
					2'h2: rd_d = cvel_q;
					default: rd_d = cpos_q;
				endcase
			end
			default: rd_d = 32'h0;
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) hrdata_q <= 32'h0;
		else if (rd_pend_q) hrdata_q <= rd_d;
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			{mode_q, gtf_q, gvel_q, gpos_q} <= '0;
			{ttq_q, tvel_q, tpos_q, scale_q, brk_q, uduq_q} <= '0;
			flux_q <= 32'h0;
			isel_q <= 2'h0;
			vlim_q <= `FPC_S16_MAX;
			tflim_q <= `FPC_S16_MAX;
			vellim_q <= `FPC_S32_MAX;
			posmin_q <= `FPC_S32_MIN;
			posmax_q <= `FPC_S32_MAX;
		end else if (wr_act_q) begin
			case (ix_q)
				`FPC_IX_MODE: mode_q <= hwdata_in;
				`FPC_IX_GAIN_TF: gtf_q <= hwdata_in;
				`FPC_IX_GAIN_VEL: gvel_q <= hwdata_in;
				`FPC_IX_GAIN_POS: gpos_q <= hwdata_in;
				`FPC_IX_TGT_TQ: ttq_q <= hwdata_in;
				`FPC_IX_TGT_VEL: tvel_q <= hwdata_in;
				`FPC_IX_TGT_POS: tpos_q <= hwdata_in;
				`FPC_IX_SCALE: scale_q <= hwdata_in;
				`FPC_IX_BRAKE: brk_q <= hwdata_in;
				`FPC_IX_UDUQ: uduq_q <= hwdata_in;
				`FPC_IX_VLIM: vlim_q <= hwdata_in;
				`FPC_IX_TFLIM: tflim_q <= hwdata_in;
				`FPC_IX_VELLIM: vellim_q <= hwdata_in;
				`FPC_IX_POSMIN: posmin_q <= hwdata_in;
				`FPC_IX_POSMAX: posmax_q <= hwdata_in;
				`FPC_IX_FLUX: flux_q <= hwdata_in;
				`FPC_IX_ISEL: isel_q <= hwdata_in[1:0];
				default: ;
			endcase
		end
	end

	// ****************************************
	// target sources and motion modes
	// ****************************************
	logic [3:0] mm;
	logic [1:0] motor;
	logic       adv, pq, iq, is_tq, is_vel, is_pos, pin_pwm;
	fpc_w_t     an_sc, pw_sc, src, pos_hold_q, vlim, tflim, vellim;

	assign mm = mode_q[`FPC_F_MM];
	assign motor = mode_q[`FPC_F_MOTOR];
	assign adv = mode_q[`FPC_B_ADV];
	assign pq = mode_q[`FPC_B_PQ412];
	assign iq = mode_q[`FPC_B_IQ412];
	assign vlim = fpc_w_t'(signed'(vlim_q[`FPC_F_LO16]));
	assign tflim = fpc_w_t'(signed'(tflim_q[`FPC_F_LO16]));
	assign vellim = vellim_q;
	assign is_tq = mm inside {`FPC_MM_TQ, `FPC_MM_A_TQ, `FPC_MM_P_TQ};
	assign is_vel = mm inside {`FPC_MM_VEL, `FPC_MM_A_VEL, `FPC_MM_P_VEL};
	assign is_pos = mm inside {`FPC_MM_POS, `FPC_MM_A_POS, `FPC_MM_P_POS};
	assign pin_pwm = mm inside {`FPC_MM_P_TQ, `FPC_MM_P_VEL, `FPC_MM_P_POS};
	assign reserved_mode = !(is_tq || is_vel || is_pos ||
		mm == `FPC_MM_STOP || mm == `FPC_MM_UDUQ);

	// offset then gain in q8.8
	assign an_sc = sat((fpc_l_t'(analog_target_input_in) -
		fpc_l_t'(signed'(scale_q[`FPC_F_LO16]))) *
		fpc_l_t'(signed'(scale_q[`FPC_F_HI16])) >>> `FPC_SCALE_SH,
		`FPC_S32_MIN, `FPC_S32_MAX);
	assign pw_sc = sat((fpc_l_t'(pwm_target_in) -
		fpc_l_t'(signed'(scale_q[`FPC_F_LO16]))) *
		fpc_l_t'(signed'(scale_q[`FPC_F_HI16])) >>> `FPC_SCALE_SH,
		`FPC_S32_MIN, `FPC_S32_MAX);

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) pos_hold_q <= 32'sh0;
		else if (pwm_tick_in && pwm_target_ok_in) pos_hold_q <= pw_sc;
	end

	always_comb begin
		if (mm >= `FPC_MM_P_TQ)
			src = pwm_target_ok_in ? pw_sc : (is_pos ? pos_hold_q : '0);
		else if (mm >= `FPC_MM_A_TQ) src = an_sc;
		else if (is_pos)
			src = mode_q[`FPC_B_STEPDIR] ? stepdir_pos_in
				: fpc_w_t'(tpos_q);
		else if (is_vel) src = tvel_q;
		else src = ttq_q;
	end

	// ****************************************
	// pi cascade, once per pwm cycle; position loop every FPC_F_DS+1 cycles
	// ****************************************
	fpc_pkg::fpc_pi_s pos_q, vel_q, tq_q, fx_q, pos_d, vel_d, tq_d, fx_d;
	fpc_w_t           ptgt, vtgt, ttgt, ftgt;
	logic [6:0]       ds_q;
	logic             pos_run;

	assign pos_run = pwm_tick_in && ds_q == 7'h0;
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) ds_q <= 7'h0;
		else if (pwm_tick_in)
			ds_q <= (ds_q >= mode_q[`FPC_F_DS]) ? 7'h0
				: ds_q + 7'h1;
	end

	always_comb begin
		ptgt = sat(fpc_l_t'(src), posmin_q, posmax_q);
		vtgt = sat(fpc_l_t'(is_pos ? pos_q.out : src),
			-vellim, vellim);
		ttgt = sat(fpc_l_t'((is_pos || is_vel) ? vel_q.out : src),
			-tflim, tflim);
		ftgt = sat(fpc_l_t'(signed'(flux_q)), -tflim, tflim);
	end

	// ****************************************
	// current transforms
	// ****************************************
	fpc_l_t ia, ib, va, vb;
	fpc_w_t id, iqa, ud, uq;
	fpc_pkg::fpc_phase_s ph_d, ph_q;

	always_comb begin
		ia = fpc_l_t'(i_u_in);
		ib = fpc_l_t'(i_v_in);
		if (motor != `FPC_MOT_TWO)
			ib = ((fpc_l_t'(i_v_in) - fpc_l_t'(i_w_in)) *
				`FPC_INV_SQRT3) >>> `FPC_TRIG_SH;
		id = fpc_w_t'((ia * cos_in + ib * sin_in) >>> `FPC_TRIG_SH);
		iqa = fpc_w_t'((ib * cos_in - ia * sin_in) >>> `FPC_TRIG_SH);
		if (motor == `FPC_MOT_DC) begin
			id = 32'sh0;
			iqa = fpc_w_t'(i_u_in);
		end
		pos_d = pi_step(ptgt - pos_act_in, gpos_q[`FPC_F_LO16],
			gpos_q[`FPC_F_HI16], pos_q.integ, vellim, adv, pq, iq, !adv);
		vel_d = pi_step(vtgt - vel_act_in, gvel_q[`FPC_F_LO16],
			gvel_q[`FPC_F_HI16], vel_q.integ, tflim, adv, pq, iq, 1'b0);
		tq_d = pi_step(ttgt - iqa, gtf_q[`FPC_F_LO16], gtf_q[`FPC_F_HI16],
			tq_q.integ, vlim, adv, pq, iq, 1'b0);
		fx_d = pi_step(ftgt - id, gtf_q[`FPC_F_LO16], gtf_q[`FPC_F_HI16],
			fx_q.integ, vlim, adv, pq, iq, 1'b0);
		ud = fx_d.out;
		uq = tq_d.out;
		if (mm == `FPC_MM_UDUQ) begin
			ud = fpc_w_t'(signed'(uduq_q[`FPC_F_LO16]));
			uq = fpc_w_t'(signed'(uduq_q[`FPC_F_HI16]));
		end
		va = (fpc_l_t'(ud) * cos_in - fpc_l_t'(uq) * sin_in) >>> `FPC_TRIG_SH;
		vb = (fpc_l_t'(ud) * sin_in + fpc_l_t'(uq) * cos_in) >>> `FPC_TRIG_SH;
		ph_d = '0;
		if (motor == `FPC_MOT_DC) begin
			ph_d.u = uq[15:0];
			ph_d.v = 16'(-uq);
		end else if (motor == `FPC_MOT_TWO) begin
			ph_d.u = va[15:0];
			ph_d.v = vb[15:0];
		end else begin
			ph_d.u = va[15:0];
			ph_d.v = 16'(((vb * `FPC_SQRT3_HALF) >>> `FPC_TRIG_SH) - (va >>> 1));
			ph_d.w = 16'(-((vb * `FPC_SQRT3_HALF) >>> `FPC_TRIG_SH) -
				(va >>> 1));
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in || (pwm_tick_in && (mm == `FPC_MM_STOP ||
			reserved_mode))) begin
			{pos_q, vel_q, tq_q, fx_q, ph_q} <= '0;
			{ctq_q, cfx_q, cvel_q, cpos_q} <= '0;
		end else if (pwm_tick_in) begin
			if (pos_run && is_pos) pos_q <= pos_d;
			if (is_pos || is_vel) vel_q <= vel_d;
			if (mm != `FPC_MM_UDUQ) begin
				tq_q <= tq_d;
				fx_q <= fx_d;
			end
			ph_q <= ph_d;
			ctq_q <= ttgt;
			cfx_q <= ftgt;
			cvel_q <= vtgt;
			cpos_q <= ptgt;
		end
	end
	assign phase_out = ph_q;

	// ****************************************
	// brake chopper
	// ****************************************
	logic [15:0] up, lo;
	assign up = brk_q[`FPC_F_LO16];
	assign lo = brk_q[`FPC_F_HI16];
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) brake_q <= 1'b0;
		else if (pwm_tick_in) begin
			if (up == 16'h0 && lo == 16'h0) brake_q <= 1'b0;
			else if (supply_in > up) brake_q <= 1'b1;
			else if (supply_in < lo) brake_q <= 1'b0;
		end
	end
	assign brake_out = brake_q;

	// ****************************************
	// checks
	// ****************************************
	chk_lim_reset: assert property (@(posedge clk_sys_in)
		$past(reset_in) && !reset_in |-> vellim_q == `FPC_S32_MAX &&
		posmin_q == `FPC_S32_MIN && vlim_q == `FPC_S16_MAX)
		else $error("limits not at maximum after reset");
	chk_vel_clip: assert property (
		@(posedge clk_sys_in) disable iff (reset_in)
		pwm_tick_in && vellim >= 0 && !reserved_mode &&
		mm != `FPC_MM_STOP |=> cvel_q <= $past(vellim) &&
		cvel_q >= -$past(vellim))
		else $error("velocity target outside limit");
	chk_pos_clip: assert property (
		@(posedge clk_sys_in) disable iff (reset_in)
		pwm_tick_in && fpc_w_t'(posmin_q) <= fpc_w_t'(posmax_q) |=>
		(cpos_q <= $past(fpc_w_t'(posmax_q)) &&
		cpos_q >= $past(fpc_w_t'(posmin_q))) || cpos_q == 0)
		else $error("position target outside its window");
	chk_volt_clip: assert property (
		@(posedge clk_sys_in) disable iff (reset_in)
		pwm_tick_in && vlim >= 0 && mm != `FPC_MM_UDUQ |=>
		tq_q.out <= $past(vlim) && tq_q.out >= -$past(vlim))
		else $error("torque output outside voltage limit");
	chk_brake_off: assert property (
		@(posedge clk_sys_in) disable iff (reset_in)
		pwm_tick_in && up == 0 && lo == 0 |=> !brake_out)
		else $error("brake active with zero thresholds");
	chk_brake_on: assert property (
		@(posedge clk_sys_in) disable iff (reset_in)
		pwm_tick_in && supply_in > up && up != 0 |=> brake_out)
		else $error("brake not raised above upper threshold");
	chk_brake_hold: assert property (
		@(posedge clk_sys_in) disable iff (reset_in)
		!pwm_tick_in |=> $stable(brake_out))
		else $error("brake changed inside a pwm cycle");
	chk_stop_zero: assert property (
		@(posedge clk_sys_in) disable iff (reset_in)
		pwm_tick_in && mm == `FPC_MM_STOP |=> phase_out == '0)
		else $error("phases driven in stopped mode");
	chk_dc_bridge: assert property (
		@(posedge clk_sys_in) disable iff (reset_in)
		pwm_tick_in && motor == `FPC_MOT_DC |=>
		phase_out.w == 0 && phase_out.y == 0)
		else $error("dc motor drives second bridge");
	chk_ds_rate: assert property (
		@(posedge clk_sys_in) disable iff (reset_in)
		pwm_tick_in && ds_q != 0 && is_pos |=> $stable(pos_q))
		else $error("position loop ran off its sample slot");
endmodule : fpc_core

/* File: verilog/fpc_pkg.sv */
// carrier types of the servo control core
package fpc_pkg;
	typedef struct packed {
		logic signed [31:0] out;
		logic signed [31:0] integ;
	} fpc_pi_s;
	typedef struct packed {
		logic signed [15:0] u;
		logic signed [15:0] v;
		logic signed [15:0] w;
		logic signed [15:0] y;
	} fpc_phase_s;
endpackage : fpc_pkg
